// file: design/vic_pkg.sv
// Constants for the video input configuration register slice.
// Assumes an 8-bit register port and one system clock.
package vic_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] VIC_ADDR_MISC = 8'h03;
  localparam logic [7:0] VIC_ADDR_POLFMT = 8'h04;
  localparam logic [7:0] VIC_ADDR_VRES = 8'h05;
  localparam logic [7:0] VIC_ADDR_VLOW = 8'h06;
  // ==========================================================
  // Reset values
  localparam logic [7:0] VIC_RST_MISC = 8'h70;
  localparam logic [7:0] VIC_RST_POLFMT = 8'h10;
  localparam logic [7:0] VIC_RST_VRES = 8'h20;
  localparam logic [7:0] VIC_RST_VLOW = 8'hD0;
  // ==========================================================
  // Field positions, misc register
  localparam int VIC_POS_PWRON = 6;
  localparam int VIC_POS_PWROFF = 5;
  localparam int VIC_POS_DETECT = 4;
  localparam int VIC_POS_PANEL = 3;
  localparam int VIC_POS_FILT_EN = 2;
  localparam int VIC_POS_FILT_LEN = 0;
  localparam logic [7:0] VIC_MASK_MISC = 8'h7F;
  // Field positions, polarity and format register
  localparam int VIC_POS_DV_INV = 7;
  localparam int VIC_POS_VS_INV = 6;
  localparam int VIC_POS_HS_INV = 5;
  localparam int VIC_POS_EDGE = 4;
  localparam int VIC_POS_REVERSE = 3;
  localparam int VIC_POS_BLACK = 2;
  localparam int VIC_POS_SWAP = 1;
  localparam int VIC_POS_DEPTH = 0;
  // Field positions, line count and resolution
  localparam int VIC_POS_LINES_HI = 4;
  localparam int VIC_POS_RES = 0;
  localparam logic [7:0] VIC_MASK_VLOW = 8'hFE;
  // ==========================================================
  // Widths
  localparam int VIC_COMP_W = 8;
  localparam int VIC_PIX_W = 24;
  localparam int VIC_LINES_W = 12;
  localparam logic [VIC_PIX_W-1:0] VIC_PIX_BLACK = 24'h000000;
endpackage

// file: design/vic_glitch_filter.sv
// Glitch filter for one timing input.
// Assumes the input is synchronous to the system clock.
`timescale 1ns/1ps
module vic_glitch_filter (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Control
  input wire logic EN,
  input wire logic [1:0] LEN,
  // Signal
  input wire logic DIN,
  output logic DOUT
);
  logic dout_q, dout_d;
  logic [1:0] cnt_q, cnt_d;

  // ==========================================================
  // Stability counter
  always_comb begin
    dout_d = dout_q;
    cnt_d = 2'h0;
    if (!EN) begin
      dout_d = DIN;
    end else if (DIN != dout_q) begin
      if (cnt_q == LEN) begin
        dout_d = DIN;
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      dout_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      dout_q <= dout_d;
      cnt_q <= cnt_d;
    end
  end

  assign DOUT = dout_q;

  // ==========================================================
  // Checks
  a_filter_holds: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (EN && (DIN != dout_q) && (cnt_q != LEN)) |=> (dout_q == $past(dout_q)))
    else $error("filter output changed before span elapsed");
  a_filter_passes: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (EN && LEN == 2'h0 && DIN != dout_q) |=> (dout_q == $past(DIN)))
    else $error("one clock span did not pass input");
  a_filter_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !EN |=> (dout_q == $past(DIN)))
    else $error("disabled filter did not pass input");
endmodule // vic_glitch_filter

// file: design/vic_regs.sv
// Video input configuration registers, strap override and input qualification.
// Assumes a synchronous byte-wide register port and synchronous video inputs.
// What this block does
// - Power-on fill select, black by default
// - Power-off fill select, black by default
// - Lost-input detection enable, enabled by default
// - Strap source is flip XOR strap pin
// - Software strap: panel kind is bit XOR pin
// - Timing de-noise enable, off after reset
// - Filter length codes give one to four clocks
// - Data-valid polarity invert bit
// - Vertical sync polarity invert bit
// - Horizontal sync polarity invert bit
// - Parallel input pixel clock edge select
// - Parallel input component bit order reversal
// - Force black replaces incoming pixel data
// - Swap red and blue components
// - Software strap: colour depth is bit XOR pin
// - Twelve-bit even line count over two registers
// - Software strap: resolution bits XOR pins
`timescale 1ns/1ps
module vic_regs (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [7:0] REG_RDATA,
  // Strap pins
  input wire logic STRAP_SOURCE_PIN,
  input wire logic STRAP_SOURCE_FLIP,
  input wire logic PANEL_KIND_PIN,
  input wire logic COLOR_DEPTH_PIN,
  input wire logic [3:0] RESOLUTION_PIN,
  // Video inputs
  input wire logic IS_TTL,
  input wire logic DATA_VALID_IN,
  input wire logic VSYNC_IN,
  input wire logic HSYNC_IN,
  input wire logic [vic_pkg::VIC_PIX_W-1:0] PIX_IN,
  // Qualified video
  output logic DATA_VALID_OUT,
  output logic VSYNC_OUT,
  output logic HSYNC_OUT,
  output logic [vic_pkg::VIC_PIX_W-1:0] PIX_OUT,
  // Effective settings
  output logic STRAP_SOURCE_SEL,
  output logic PANEL_KIND_SEL,
  output logic COLOR_DEPTH_SEL,
  output logic [3:0] RESOLUTION_SEL,
  output logic PWRON_FILL_BLACK,
  output logic PWROFF_FILL_BLACK,
  output logic LOST_INPUT_DETECT_EN,
  output logic PIXCLK_EDGE_SEL,
  output logic [vic_pkg::VIC_LINES_W-1:0] ACTIVE_LINE_COUNT
);
  import vic_pkg::*;

  logic [7:0] misc_q, misc_d;
  logic [7:0] polfmt_q, polfmt_d;
  logic [7:0] vres_q, vres_d;
  logic [7:0] vlow_q, vlow_d;
  logic [7:0] rdata_q, rdata_d;
  logic [VIC_PIX_W-1:0] pix_q, pix_d;
  logic dv_q, dv_d, vs_q, vs_d, hs_q, hs_d;
  logic dv_filt, vs_filt, hs_filt;
  logic strap_sw;
  logic [VIC_COMP_W-1:0] red, green, blue;

  // ==========================================================
  // Register writes
  always_comb begin
    misc_d = misc_q;
    polfmt_d = polfmt_q;
    vres_d = vres_q;
    vlow_d = vlow_q;
    if (REG_WE) begin
      unique case (REG_ADDR)
        VIC_ADDR_MISC: misc_d = REG_WDATA & VIC_MASK_MISC;
        // polarity, edge, order, black, swap bits
        VIC_ADDR_POLFMT: polfmt_d = REG_WDATA;
        VIC_ADDR_VRES: vres_d = REG_WDATA;
        // low line bits, bit zero held zero
        VIC_ADDR_VLOW: vlow_d = REG_WDATA & VIC_MASK_VLOW;
        default: misc_d = misc_q;
      endcase
    end
  end

  // ==========================================================
  // Register read
  always_comb begin
    rdata_d = rdata_q;
    if (REG_RE) begin
      unique case (REG_ADDR)
        VIC_ADDR_MISC: rdata_d = misc_q;
        VIC_ADDR_POLFMT: rdata_d = polfmt_q;
        VIC_ADDR_VRES: rdata_d = vres_q;
        VIC_ADDR_VLOW: rdata_d = vlow_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      // black fill and detection on at reset
      misc_q <= VIC_RST_MISC;
      polfmt_q <= VIC_RST_POLFMT;
      vres_q <= VIC_RST_VRES;
      vlow_q <= VIC_RST_VLOW;
    end else begin
      misc_q <= misc_d;
      polfmt_q <= polfmt_d;
      vres_q <= vres_d;
      vlow_q <= vlow_d;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

  // ==========================================================
  // Strap source and pin overrides
  // source is flip XOR pin, zero means software
  assign STRAP_SOURCE_SEL = STRAP_SOURCE_FLIP ^ STRAP_SOURCE_PIN;
  assign strap_sw = !STRAP_SOURCE_SEL;
  assign PANEL_KIND_SEL = strap_sw ? (misc_q[VIC_POS_PANEL] ^ PANEL_KIND_PIN) : PANEL_KIND_PIN;
  assign COLOR_DEPTH_SEL = strap_sw ? (polfmt_q[VIC_POS_DEPTH] ^ COLOR_DEPTH_PIN) : COLOR_DEPTH_PIN;
  assign RESOLUTION_SEL = strap_sw ? (vres_q[VIC_POS_RES +: 4] ^ RESOLUTION_PIN) : RESOLUTION_PIN;

  // ==========================================================
  // Plain settings
  assign PWRON_FILL_BLACK = misc_q[VIC_POS_PWRON];
  assign PWROFF_FILL_BLACK = misc_q[VIC_POS_PWROFF];
  assign LOST_INPUT_DETECT_EN = misc_q[VIC_POS_DETECT];
  // edge choice matters only on parallel input
  assign PIXCLK_EDGE_SEL = IS_TTL ? polfmt_q[VIC_POS_EDGE] : 1'b1;
  // twelve-bit count, bit zero implied zero
  assign ACTIVE_LINE_COUNT = {vres_q[VIC_POS_LINES_HI +: 4], vlow_q[7:1], 1'b0};

  // ==========================================================
  // Timing input de-noise
  // enable and length feed each filter
  vic_glitch_filter u_filt_dv (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .EN(misc_q[VIC_POS_FILT_EN]),
    .LEN(misc_q[VIC_POS_FILT_LEN +: 2]),
    .DIN(DATA_VALID_IN),
    .DOUT(dv_filt)
  );
  vic_glitch_filter u_filt_vs (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .EN(misc_q[VIC_POS_FILT_EN]),
    .LEN(misc_q[VIC_POS_FILT_LEN +: 2]),
    .DIN(VSYNC_IN),
    .DOUT(vs_filt)
  );
  vic_glitch_filter u_filt_hs (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .EN(misc_q[VIC_POS_FILT_EN]),
    .LEN(misc_q[VIC_POS_FILT_LEN +: 2]),
    .DIN(HSYNC_IN),
    .DOUT(hs_filt)
  );

  // ==========================================================
  // Polarity and timing output registers
  always_comb begin
    dv_d = dv_filt ^ polfmt_q[VIC_POS_DV_INV];
    vs_d = vs_filt ^ polfmt_q[VIC_POS_VS_INV];
    hs_d = hs_filt ^ polfmt_q[VIC_POS_HS_INV];
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      dv_q <= 1'b0;
      vs_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      dv_q <= dv_d;
      vs_q <= vs_d;
      hs_q <= hs_d;
    end
  end

  // ==========================================================
  // Pixel path
  always_comb begin
    red = PIX_IN[16 +: VIC_COMP_W];
    green = PIX_IN[8 +: VIC_COMP_W];
    blue = PIX_IN[0 +: VIC_COMP_W];
    // reverse bit order on parallel input
    if (IS_TTL && polfmt_q[VIC_POS_REVERSE]) begin
      red = {<<{red}};
      green = {<<{green}};
      blue = {<<{blue}};
    end
    if (polfmt_q[VIC_POS_SWAP]) begin
      pix_d = {blue, green, red};
    end else begin
      pix_d = {red, green, blue};
    end
    if (polfmt_q[VIC_POS_BLACK]) begin
      pix_d = VIC_PIX_BLACK;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pix_q <= VIC_PIX_BLACK;
    end else begin
      pix_q <= pix_d;
    end
  end

  assign DATA_VALID_OUT = dv_q;
  assign VSYNC_OUT = vs_q;
  assign HSYNC_OUT = hs_q;
  assign PIX_OUT = pix_q;

  // ==========================================================
  // Checks
  a_pwroff_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_MISC) |=> (PWROFF_FILL_BLACK == $past(REG_WDATA[VIC_POS_PWROFF])))
    else $error("power-off fill bit not written");

  a_detect_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_MISC) |=> (LOST_INPUT_DETECT_EN == $past(REG_WDATA[VIC_POS_DETECT])))
    else $error("detect enable not written");

  a_pwron_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_MISC) |=> (PWRON_FILL_BLACK == $past(REG_WDATA[VIC_POS_PWRON])))
    else $error("power-on fill bit not written");

  a_filt_en_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_MISC) |=> (misc_q[VIC_POS_FILT_EN] == $past(REG_WDATA[VIC_POS_FILT_EN])))
    else $error("filter enable not written");

  a_filt_len_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_MISC) |=> (misc_q[1:0] == $past(REG_WDATA[1:0])))
    else $error("filter length not written");

  a_read_back: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_RE && REG_ADDR == VIC_ADDR_MISC) |=> (REG_RDATA == $past(misc_q)))
    else $error("misc register read back wrong");

  a_strap_hw: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (STRAP_SOURCE_FLIP != STRAP_SOURCE_PIN) |-> (PANEL_KIND_SEL == PANEL_KIND_PIN
      && RESOLUTION_SEL == RESOLUTION_PIN && COLOR_DEPTH_SEL == COLOR_DEPTH_PIN))
    else $error("hardware strap not taken from pins");

  a_panel_sw: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_MISC) ##1 (STRAP_SOURCE_FLIP == STRAP_SOURCE_PIN)
      |-> (PANEL_KIND_SEL == ($past(REG_WDATA[VIC_POS_PANEL]) ^ PANEL_KIND_PIN)))
    else $error("software panel kind wrong");

  a_depth_sw: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_POLFMT) ##1 (STRAP_SOURCE_FLIP == STRAP_SOURCE_PIN)
      |-> (COLOR_DEPTH_SEL == ($past(REG_WDATA[VIC_POS_DEPTH]) ^ COLOR_DEPTH_PIN)))
    else $error("software colour depth wrong");

  a_res_sw: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_VRES) ##1 (STRAP_SOURCE_FLIP == STRAP_SOURCE_PIN)
      |-> (RESOLUTION_SEL == ($past(REG_WDATA[3:0]) ^ RESOLUTION_PIN)))
    else $error("software resolution wrong");

  a_lines_even: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_VLOW) |=> (ACTIVE_LINE_COUNT[7:0] == {$past(REG_WDATA[7:1]), 1'b0}))
    else $error("line count low part wrong");

  a_lines_high: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_VRES) |=> (ACTIVE_LINE_COUNT[11:8] == $past(REG_WDATA[7:4])))
    else $error("line count high part wrong");

  a_vlow_read: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_RE && REG_ADDR == VIC_ADDR_VLOW) |=> (REG_RDATA[0] == 1'b0))
    else $error("line count bit zero not zero");

  a_edge_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (REG_WE && REG_ADDR == VIC_ADDR_POLFMT) ##1 IS_TTL
      |-> (PIXCLK_EDGE_SEL == $past(REG_WDATA[VIC_POS_EDGE])))
    else $error("parallel clock edge not written");

  a_edge_other: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !IS_TTL |-> PIXCLK_EDGE_SEL)
    else $error("clock edge not rising off parallel input");

  a_black_out: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    polfmt_q[VIC_POS_BLACK] |=> (PIX_OUT == VIC_PIX_BLACK))
    else $error("forced black not shown");

  a_swap_path: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (polfmt_q[VIC_POS_SWAP] && !polfmt_q[VIC_POS_BLACK] && !polfmt_q[VIC_POS_REVERSE])
      |=> (PIX_OUT[23:16] == $past(PIX_IN[7:0]) && PIX_OUT[7:0] == $past(PIX_IN[23:16])))
    else $error("red and blue not swapped");

  a_plain_path: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!polfmt_q[VIC_POS_SWAP] && !polfmt_q[VIC_POS_BLACK] && !(IS_TTL && polfmt_q[VIC_POS_REVERSE]))
      |=> (PIX_OUT == $past(PIX_IN)))
    else $error("pixel not passed in order");

  a_reverse_path: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (IS_TTL && polfmt_q[VIC_POS_REVERSE] && !polfmt_q[VIC_POS_SWAP] && !polfmt_q[VIC_POS_BLACK])
      |=> (PIX_OUT[23] == $past(PIX_IN[16]) && PIX_OUT[16] == $past(PIX_IN[23])
        && PIX_OUT[0] == $past(PIX_IN[7])))
    else $error("component bit order not reversed");

  a_dv_invert: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!misc_q[VIC_POS_FILT_EN] && polfmt_q[VIC_POS_DV_INV] && $stable(polfmt_q)) ##1 $stable(polfmt_q)
      |=> (DATA_VALID_OUT == !$past(DATA_VALID_IN, 2)))
    else $error("data-valid invert wrong");

  a_vs_invert: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!misc_q[VIC_POS_FILT_EN] && polfmt_q[VIC_POS_VS_INV] && $stable(polfmt_q)) ##1 $stable(polfmt_q)
      |=> (VSYNC_OUT == !$past(VSYNC_IN, 2)))
    else $error("vertical sync invert wrong");

  a_hs_invert: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!misc_q[VIC_POS_FILT_EN] && polfmt_q[VIC_POS_HS_INV] && $stable(polfmt_q)) ##1 $stable(polfmt_q)
      |=> (HSYNC_OUT == !$past(HSYNC_IN, 2)))
    else $error("horizontal sync invert wrong");
endmodule // vic_regs

// file: test/vic_host_model.sv
// Host microcontroller and video source model for the configuration block.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module vic_host_model (
  // Clock
  input wire logic CLK_SYS,
  // Register port
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WE,
  output logic REG_RE,
  input wire logic [7:0] REG_RDATA,
  // Video source
  output logic DATA_VALID_IN,
  output logic VSYNC_IN,
  output logic HSYNC_IN,
  output logic [23:0] PIX_IN
);
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WE = 1'b0;
    REG_RE = 1'b0;
    {DATA_VALID_IN, VSYNC_IN, HSYNC_IN} = 3'h0;
    PIX_IN = 24'h000000;
  end
  // =====
  // One write, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WE <= 1'b1;
    @(posedge CLK_SYS);
    REG_WE <= 1'b0;
    REG_WDATA <= ~d;
  endtask
  // =====
  // One read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RE <= 1'b1;
    @(posedge CLK_SYS);
    REG_RE <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask
  // =====
  // Timing and pixel sample
  task automatic vid(input logic [2:0] s, input logic [23:0] p);
    @(posedge CLK_SYS);
    {DATA_VALID_IN, VSYNC_IN, HSYNC_IN} <= s;
    PIX_IN <= p;
  endtask
endmodule // vic_host_model

// file: test/tb_top.sv
// Self-checking bench for the video input configuration registers.
// Assumes the host model drives the register port and timing inputs.
`timescale 1ns/1ps
module tb_top;
  import vic_pkg::*;
  logic CLK_SYS, RSTN, REG_WE, REG_RE, IS_TTL, STRAP_SOURCE_PIN, STRAP_SOURCE_FLIP;
  logic PANEL_KIND_PIN, COLOR_DEPTH_PIN, DATA_VALID_IN, VSYNC_IN, HSYNC_IN;
  logic DATA_VALID_OUT, VSYNC_OUT, HSYNC_OUT, STRAP_SOURCE_SEL, PANEL_KIND_SEL, COLOR_DEPTH_SEL;
  logic PWRON_FILL_BLACK, PWROFF_FILL_BLACK, LOST_INPUT_DETECT_EN, PIXCLK_EDGE_SEL;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, rd_val;
  logic [3:0] RESOLUTION_PIN, RESOLUTION_SEL;
  logic [VIC_PIX_W-1:0] PIX_IN, PIX_OUT;
  logic [VIC_LINES_W-1:0] ACTIVE_LINE_COUNT;
  int err_count, compares;
  vic_regs u_vic_regs (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
    .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .STRAP_SOURCE_PIN(STRAP_SOURCE_PIN),
    .STRAP_SOURCE_FLIP(STRAP_SOURCE_FLIP), .PANEL_KIND_PIN(PANEL_KIND_PIN), .COLOR_DEPTH_PIN(COLOR_DEPTH_PIN),
    .RESOLUTION_PIN(RESOLUTION_PIN), .IS_TTL(IS_TTL), .DATA_VALID_IN(DATA_VALID_IN), .VSYNC_IN(VSYNC_IN),
    .HSYNC_IN(HSYNC_IN), .PIX_IN(PIX_IN), .DATA_VALID_OUT(DATA_VALID_OUT), .VSYNC_OUT(VSYNC_OUT),
    .HSYNC_OUT(HSYNC_OUT), .PIX_OUT(PIX_OUT), .STRAP_SOURCE_SEL(STRAP_SOURCE_SEL),
    .PANEL_KIND_SEL(PANEL_KIND_SEL), .COLOR_DEPTH_SEL(COLOR_DEPTH_SEL), .RESOLUTION_SEL(RESOLUTION_SEL),
    .PWRON_FILL_BLACK(PWRON_FILL_BLACK), .PWROFF_FILL_BLACK(PWROFF_FILL_BLACK),
    .LOST_INPUT_DETECT_EN(LOST_INPUT_DETECT_EN), .PIXCLK_EDGE_SEL(PIXCLK_EDGE_SEL),
    .ACTIVE_LINE_COUNT(ACTIVE_LINE_COUNT)
  );
  vic_host_model u_vic_host_model (
    .CLK_SYS(CLK_SYS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
    .REG_RDATA(REG_RDATA), .DATA_VALID_IN(DATA_VALID_IN), .VSYNC_IN(VSYNC_IN), .HSYNC_IN(HSYNC_IN),
    .PIX_IN(PIX_IN)
  );
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // =====
  // Helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_vic_host_model.rd(a, rd_val);
    chk(rd_val, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int k = 0; k < 8; k++) rev8[k] = b[7-k];
  endfunction
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // =====
  // Scenarios
  task automatic t_reset;
    chk({PWRON_FILL_BLACK, PWROFF_FILL_BLACK, LOST_INPUT_DETECT_EN}, 3'b111);
    chk(ACTIVE_LINE_COUNT, 12'h2D0);
    chk(PIXCLK_EDGE_SEL, 1'b1);
    rdchk(VIC_ADDR_MISC, 8'h70);
    rdchk(VIC_ADDR_POLFMT, 8'h10);
    rdchk(VIC_ADDR_VRES, 8'h20);
    rdchk(VIC_ADDR_VLOW, 8'hD0);
    rdchk(8'h07, 8'h00);
  endtask
  task automatic t_pol;
    logic [3:0] m;
    logic [2:0] x;
    logic [2:0] nx;
    for (int i = 0; i < 4; i++) begin
      m = 4'b1000 >> i;
      x = 3'b101 ^ i[2:0];
      nx = ~x;
      u_vic_host_model.wr(VIC_ADDR_POLFMT, {m[2:0], 5'h10});
      u_vic_host_model.vid(nx, 24'h0);
      cyc(2);
      u_vic_host_model.vid(x, 24'h0);
      cyc(1);
      chk({DATA_VALID_OUT, VSYNC_OUT, HSYNC_OUT}, nx ^ m[2:0]);
      cyc(1);
      chk({DATA_VALID_OUT, VSYNC_OUT, HSYNC_OUT}, x ^ m[2:0]);
    end
  endtask
  task automatic t_filt;
    u_vic_host_model.wr(VIC_ADDR_POLFMT, 8'h10);
    for (int c = 0; c < 4; c++) begin
      u_vic_host_model.wr(VIC_ADDR_MISC, {5'b01110, 1'b1, c[1:0]});
      u_vic_host_model.vid(3'b000, 24'h0);
      cyc(c + 3);
      if (c > 0) begin
        u_vic_host_model.vid(3'b100, 24'h0);
        repeat (c - 1) @(posedge CLK_SYS);
        u_vic_host_model.vid(3'b000, 24'h0);
        repeat (8) begin
          cyc(1);
          chk(DATA_VALID_OUT, 1'b0);
        end
      end
      u_vic_host_model.vid(3'b111, 24'h0);
      cyc(c + 1);
      chk({DATA_VALID_OUT, VSYNC_OUT, HSYNC_OUT}, 3'b000);
      cyc(1);
      chk({DATA_VALID_OUT, VSYNC_OUT, HSYNC_OUT}, 3'b111);
    end
    u_vic_host_model.wr(VIC_ADDR_MISC, 8'h70);
  endtask
  task automatic t_pix;
    logic [3:0] v;
    logic [23:0] p;
    logic [23:0] q;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      p = 24'h12C3A5 ^ {3{4'h0, v}};
      u_vic_host_model.wr(VIC_ADDR_POLFMT, {3'b000, !v[0], v[0], v[1], v[2], 1'b0});
      @(posedge CLK_SYS);
      IS_TTL <= v[3];
      u_vic_host_model.vid(3'b000, p);
      cyc(1);
      q = (v[0] & v[3]) ? {rev8(p[23:16]), rev8(p[15:8]), rev8(p[7:0])} : p;
      q = v[2] ? {q[7:0], q[15:8], q[23:16]} : q;
      chk(PIX_OUT, v[1] ? 24'h000000 : q);
      chk(PIXCLK_EDGE_SEL, v[3] ? !v[0] : 1'b1);
    end
  endtask
  task automatic t_strap;
    logic [3:0] v;
    logic [3:0] rr;
    logic [3:0] pins;
    logic hw;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      rr = v[2] ? 4'hA : 4'h5;
      pins = v[3] ? 4'hC : 4'h3;
      hw = v[0] ^ v[1];
      u_vic_host_model.wr(VIC_ADDR_MISC, {4'h7, v[2], 3'h0});
      u_vic_host_model.wr(VIC_ADDR_POLFMT, {7'h08, v[2]});
      u_vic_host_model.wr(VIC_ADDR_VRES, {4'h2, rr});
      @(posedge CLK_SYS);
      STRAP_SOURCE_FLIP <= v[0];
      STRAP_SOURCE_PIN <= v[1];
      PANEL_KIND_PIN <= v[3];
      COLOR_DEPTH_PIN <= !v[3];
      RESOLUTION_PIN <= pins;
      cyc(1);
      chk(STRAP_SOURCE_SEL, hw);
      chk({PANEL_KIND_SEL, COLOR_DEPTH_SEL}, hw ? {v[3], !v[3]} : {v[2] ^ v[3], !(v[2] ^ v[3])});
      chk(RESOLUTION_SEL, hw ? pins : rr ^ pins);
    end
  endtask
  task automatic t_regs;
    u_vic_host_model.wr(VIC_ADDR_MISC, 8'h8F);
    cyc(1);
    chk({PWRON_FILL_BLACK, PWROFF_FILL_BLACK, LOST_INPUT_DETECT_EN}, 3'b000);
    rdchk(VIC_ADDR_MISC, 8'h0F);
    u_vic_host_model.wr(VIC_ADDR_VRES, 8'h5A);
    u_vic_host_model.wr(VIC_ADDR_VLOW, 8'h37);
    u_vic_host_model.wr(8'h07, 8'hFF);
    cyc(1);
    chk(ACTIVE_LINE_COUNT, 12'h536);
    rdchk(VIC_ADDR_VLOW, 8'h36);
    rdchk(8'h07, 8'h00);
    u_vic_host_model.wr(VIC_ADDR_VRES, 8'hF0);
    u_vic_host_model.wr(VIC_ADDR_VLOW, 8'hFE);
    cyc(1);
    chk(ACTIVE_LINE_COUNT, 12'hFFE);
  endtask
  // =====
  // Main sequence and watchdog
  initial begin
    RSTN = 1'b0;
    IS_TTL = 1'b0;
    {STRAP_SOURCE_PIN, STRAP_SOURCE_FLIP, PANEL_KIND_PIN, COLOR_DEPTH_PIN} = 4'h0;
    RESOLUTION_PIN = 4'h0;
    err_count = 0;
    compares = 0;
    repeat (3) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    cyc(1);
    t_reset;
    t_pol;
    t_filt;
    t_pix;
    t_strap;
    t_regs;
    @(posedge CLK_SYS);
    RSTN <= 1'b0;
    cyc(2);
    @(posedge CLK_SYS);
    RSTN <= 1'b1;
    cyc(1);
    t_reset;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    err_count++;
    tally_and_finish;
  end
endmodule // tb_top
